//--- logic/panel_control.sv
/*
  Operator panel control and control-word decode for the microprogrammed board,
  with its 256 x 32 writable control store and an APB register slave.
  Assumes panel switches are asynchronous, data path and sequencer signals share
  CLK_SYS, and the sequencer returns its next address on SEQ_NEXT_ADDR.
*/
`timescale 1ns/100ps

module panel_control
  import panel_pkg::*;
#(
  parameter int          DEBOUNCE_LIMIT = DEBOUNCE_CYCLES,
  parameter logic [3:0]  RETURN_CODE    = 4'h0
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic [7:0]  INPUT_SWITCHES,
  input  wire logic [2:0]  MULTIWAY_SWITCHES,
  input  wire logic [1:0]  BUS_VIEW_SELECT,
  input  wire logic        CLOCK_SELECT,
  input  wire logic        EXTERNAL_CLOCK_INPUT,
  input  wire logic [6:0]  PANEL_BUTTONS,
  input  wire logic [7:0]  SEQ_NEXT_ADDR,
  input  wire logic        SEQUENCER_INHIBIT,
  input  wire logic        SHIFT_LEFT_OUT_N,
  input  wire logic        SHIFT_RIGHT_OUT_N,
  input  wire logic [7:0]  SHIFTER_IN_BUS,
  input  wire logic [7:0]  DATA_OUT_BUS,
  input  wire logic [7:0]  MEMORY_BUS,
  output logic             SYSTEM_CLOCK,
  output logic             SEQUENCER_CLOCK,
  output logic      [3:0]  SEQ_INSTR,
  output logic      [7:0]  SEQ_BRANCH_ADDR,
  output logic      [2:0]  SEQ_MULTIWAY,
  output logic      [3:0]  OUTPUT_ENABLE_N,
  output logic      [2:0]  EXECUTE_ENABLE_N,
  output logic      [3:0]  STACK_INSTR,
  output logic      [5:0]  SHIFTER_INSTR,
  output logic             SHIFT_LSB_IN_N,
  output logic             SHIFT_MSB_IN_N,
  output logic      [2:0]  ALU_DEST,
  output logic      [2:0]  ALU_SRC,
  output logic      [2:0]  ALU_INSTR,
  output logic             ALU_EXECUTE_N,
  output logic             MEM_BUS_ENABLE,
  output logic             SLICE_CARRY_IN,
  output logic             SPARE_MARKER_BIT,
  output logic             ADDR_SYNC,
  output logic      [7:0]  BUS_LEDS,
  output logic      [7:0]  ADDRESS_LEDS,
  output logic      [7:0]  DATA_LEDS,
  output logic      [1:0]  FIELD_LEDS,
  output logic             RUN_LED
);

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  // One-of-four active-low decode, shared by the enable fields.
  function automatic logic [3:0] decode_n(input logic [1:0] code);
    decode_n = ~(4'h1 << code);
  endfunction

  // Low bit of a field inside the word; field 00 is the most significant byte.
  function automatic logic [4:0] field_lsb(input logic [1:0] fs);
    field_lsb = {~fs, 3'b000};
  endfunction

  panel_in_t                in_raw;
  panel_in_t                in_s1;
  panel_in_t                in_s2;
  logic [BTN_COUNT-1:0]     press;
  logic [OSC_CNT_W-1:0]     osc_cnt_reg;
  logic                     sys_level;
  logic                     level_prev_reg;
  logic                     tick;
  mode_t                    mode_reg;
  logic [7:0]               addr_reg;
  logic [1:0]               fs_reg;
  logic [31:0]              store [STORE_WORDS];
  logic [31:0]              cw;
  logic [31:0]              ctrl_reg;
  logic                     halted;
  logic                     executing;
  logic                     do_load;
  logic                     do_deposit;
  logic                     do_advance;
  logic                     do_write_next;
  logic                     host_write;
  logic                     seq_pulse;
  logic [1:0]               fs_adv;
  logic [7:0]               addr_adv;
  logic [3:0]               cw_instr;
  logic                     is_branch;
  logic                     apb_setup;
  logic                     apb_access;
  logic                     addr_ok;
  logic [3:0]               ex_dec;

  assign in_raw = '{INPUT_SWITCHES, MULTIWAY_SWITCHES, BUS_VIEW_SELECT, CLOCK_SELECT,
                    EXTERNAL_CLOCK_INPUT, PANEL_BUTTONS};

  // Two-stage synchroniser for every panel input; only the second stage is read.
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      in_s1 <= '0;
      in_s2 <= '0;
    end else begin
      in_s1 <= in_raw;
      in_s2 <= in_s1;
    end
  end

  // Each button must hold a new level for the settling time before it counts.
  // A long count costs a few flops but rejects any realistic contact chatter.
  for (genvar b = 0; b < BTN_COUNT; b++) begin : g_debounce
    logic [DB_CNT_W-1:0] cnt_reg;
    logic                stable_reg;
    logic                press_reg;
    always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
        cnt_reg    <= '0;
        stable_reg <= 1'b0;
        press_reg  <= 1'b0;
      end else begin
        press_reg <= 1'b0;
        if (in_s2.buttons[b] == stable_reg) begin
          cnt_reg <= '0;
        end else if (cnt_reg >= DB_CNT_W'(DEBOUNCE_LIMIT - 1)) begin
          cnt_reg    <= '0;
          stable_reg <= in_s2.buttons[b];
          press_reg  <= in_s2.buttons[b];
        end else begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end
    end
    assign press[b] = press_reg;

    press_single_a: assert property (press[b] |=> !press[b])
      else $error("Button press pulse lasted more than one cycle.");
  end

  // On-board oscillator divider; the selected source sets the microcycle.
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      osc_cnt_reg    <= '0;
      level_prev_reg <= 1'b0;
    end else begin
      osc_cnt_reg    <= (osc_cnt_reg == OSC_CNT_W'(OSC_DIV - 1)) ? '0 : osc_cnt_reg + 1'b1;
      level_prev_reg <= sys_level;
    end
  end

  assign sys_level = in_s2.clock_select ? in_s2.external_clock_input
                                        : (osc_cnt_reg < OSC_CNT_W'(OSC_HIGH));
  assign tick      = sys_level && !level_prev_reg;

  // Load, deposit, next and host actions are only honoured while the machine is halted.
  assign halted        = (mode_reg == MODE_HALT) && !press[BTN_RESET];
  assign executing     = (mode_reg != MODE_HALT);
  assign do_load       = halted && press[BTN_LOAD];
  assign do_deposit    = halted && press[BTN_DEPOSIT] && !do_load;
  assign host_write    = apb_access && PWRITE && (PADDR == OFF_HOST) && halted
                         && ctrl_reg[CTRL_HOST_EN_BIT]
                         && (PWDATA[HOST_SEL_LSB +: 2] == HOST_SEL_CODE);
  assign do_write_next = halted && !do_load && !do_deposit
                         && (press[BTN_DEP_NXT] || host_write);
  assign do_advance    = do_write_next
                         || (halted && press[BTN_EXM_NXT] && !do_load && !do_deposit);
  assign fs_adv        = fs_reg + 2'b01;
  assign addr_adv      = (fs_reg == FIELD_LAST) ? addr_reg + 8'h01 : addr_reg;
  assign seq_pulse     = do_load || (do_advance && (fs_reg == FIELD_LAST));

  // Mode machine; a halt request waits for the current microcycle to end.
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      mode_reg <= MODE_HALT;
    end else if (press[BTN_RESET]) begin
      mode_reg <= MODE_HALT;
    end else begin
      unique case (mode_reg)
        MODE_HALT: begin
          if (press[BTN_RUN]) begin
            mode_reg <= MODE_RUN;
          end else if (press[BTN_STEP]) begin
            mode_reg <= MODE_STEP;
          end
        end
        MODE_RUN: begin
          if (press[BTN_RUN]) begin
            mode_reg <= tick ? MODE_HALT : MODE_STOPPING;
          end
        end
        MODE_STOPPING: begin
          if (tick) begin
            mode_reg <= MODE_HALT;
          end
        end
        MODE_STEP: begin
          if (tick) begin
            mode_reg <= MODE_HALT;
          end
        end
      endcase
    end
  end

  // Microprogram address and field select.
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      addr_reg <= '0;
      fs_reg   <= '0;
    end else if (press[BTN_RESET]) begin
      addr_reg <= '0;
      fs_reg   <= '0;
    end else if (executing && tick) begin
      addr_reg <= SEQ_NEXT_ADDR;
    end else if (do_load) begin
      addr_reg <= in_s2.input_switches;
    end else if (do_advance) begin
      addr_reg <= addr_adv;
      fs_reg   <= fs_adv;
    end
  end

  // Deposit writes the current location; deposit-next and host writes land at the already advanced location.
  always_ff @(posedge CLK_SYS) begin
    if (do_deposit) begin
      store[addr_reg][field_lsb(fs_reg) +: 8] <= in_s2.input_switches;
    end else if (do_write_next) begin
      store[addr_adv][field_lsb(fs_adv) +: 8] <= host_write ? PWDATA[HOST_DATA_LSB +: 8]
                                                             : in_s2.input_switches;
    end
  end

  assign cw        = store[addr_reg];
  assign cw_instr  = {cw[CW_SEQ_LSB], cw[CW_SEQ_LSB+1], cw[CW_SEQ_LSB+2], cw[CW_SEQ_LSB+3]};
  assign is_branch = (cw_instr != INSTR_FETCH) && (cw_instr != RETURN_CODE);
  // A function result cannot be part-selected, so the decode is held in a net first.
  assign ex_dec    = decode_n(cw[CW_EX_LSB +: 2]);

  // Sequencer instruction, clock and branch address.
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      SEQ_INSTR       <= INSTR_FETCH;
      SEQUENCER_CLOCK <= 1'b1;
      SEQ_BRANCH_ADDR <= '0;
      SEQ_MULTIWAY    <= '0;
      SYSTEM_CLOCK    <= 1'b0;
    end else begin
      if (executing) begin
        SEQ_INSTR <= cw_instr;
      end else begin
        SEQ_INSTR <= do_load ? INSTR_PANEL_BRANCH : INSTR_FETCH;
      end
      SEQUENCER_CLOCK <= executing ? sys_level : !seq_pulse;
      SEQ_BRANCH_ADDR <= do_load ? in_s2.input_switches : cw[CW_BR_LSB +: 8];
      SEQ_MULTIWAY    <= in_s2.multiway_switches;
      SYSTEM_CLOCK    <= sys_level;
    end
  end

  // Data path steering decoded from the current control word; the ALU execute strobe follows the sequencer inhibit.
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      OUTPUT_ENABLE_N  <= '1;
      EXECUTE_ENABLE_N <= '1;
      STACK_INSTR      <= '0;
      SHIFTER_INSTR    <= '0;
      SHIFT_LSB_IN_N   <= 1'b1;
      SHIFT_MSB_IN_N   <= 1'b1;
      ALU_DEST         <= '0;
      ALU_SRC          <= '0;
      ALU_INSTR        <= '0;
      ALU_EXECUTE_N    <= 1'b1;
      MEM_BUS_ENABLE   <= 1'b1;
      SLICE_CARRY_IN   <= 1'b0;
      SPARE_MARKER_BIT <= 1'b0;
    end else begin
      OUTPUT_ENABLE_N  <= decode_n(cw[CW_OE_LSB +: 2]);
      EXECUTE_ENABLE_N <= ex_dec[3:1];
      STACK_INSTR      <= cw[CW_STK_LSB +: 4];
      SHIFTER_INSTR    <= cw[CW_SHF_LSB +: 6];
      SHIFT_LSB_IN_N   <= cw[CW_ROTATE] ? SHIFT_LEFT_OUT_N : cw[CW_SHIFT_CIN];
      SHIFT_MSB_IN_N   <= cw[CW_ROTATE] ? SHIFT_RIGHT_OUT_N : cw[CW_SHIFT_CIN];
      // ALU fields are zeroed while the same bits carry a branch address.
      ALU_DEST         <= is_branch ? 3'b000 : cw[CW_DEST_LSB +: 3];
      ALU_SRC          <= is_branch ? 3'b000 : cw[CW_SRC_LSB +: 3];
      ALU_INSTR        <= is_branch ? 3'b000 : cw[CW_ALU_LSB +: 3];
      ALU_EXECUTE_N    <= SEQUENCER_INHIBIT;
      MEM_BUS_ENABLE   <= cw[CW_MEMBUS];
      SLICE_CARRY_IN   <= cw[CW_CARRY];
      SPARE_MARKER_BIT <= cw[CW_MARKER];
    end
  end

  // Panel display and test point.
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      BUS_LEDS     <= '0;
      ADDRESS_LEDS <= '0;
      DATA_LEDS    <= '0;
      FIELD_LEDS   <= '0;
      RUN_LED      <= 1'b0;
      ADDR_SYNC    <= 1'b0;
    end else begin
      unique case (in_s2.bus_view_select)
        2'b00:   BUS_LEDS <= SHIFTER_IN_BUS;
        2'b01:   BUS_LEDS <= DATA_OUT_BUS;
        2'b10:   BUS_LEDS <= MEMORY_BUS;
        2'b11:   BUS_LEDS <= 8'hFF;
      endcase
      ADDRESS_LEDS <= addr_reg;
      DATA_LEDS    <= cw[field_lsb(fs_reg) +: 8];
      FIELD_LEDS   <= fs_reg;
      RUN_LED      <= (mode_reg == MODE_RUN) || (mode_reg == MODE_STOPPING);
      ADDR_SYNC    <= (addr_reg == in_s2.input_switches);
    end
  end

  // APB slave with no wait states; read data is captured in the setup phase.
  assign apb_setup  = PSEL && !PENABLE;
  assign apb_access = PSEL && PENABLE && PREADY;
  assign addr_ok    = (PADDR == OFF_CTRL) || (PADDR == OFF_STATUS)
                      || (PADDR == OFF_FIELD) || (PADDR == OFF_HOST);

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      ctrl_reg <= CTRL_RESET;
    end else if (apb_access && PWRITE && (PADDR == OFF_CTRL)) begin
      ctrl_reg <= PWDATA & CTRL_RESET;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      PRDATA  <= '0;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= 1'b1;
      if (apb_setup) begin
        PSLVERR <= !addr_ok;
        PRDATA  <= '0;
        unique case (PADDR)
          OFF_CTRL:   PRDATA <= ctrl_reg;
          OFF_STATUS: PRDATA <= (32'(addr_reg) << STAT_ADDR_LSB)
                                | (32'(fs_reg) << STAT_FIELD_LSB)
                                | (32'(mode_reg) << STAT_MODE_LSB);
          OFF_FIELD:  PRDATA <= 32'(cw[field_lsb(fs_reg) +: 8]);
          default:    PRDATA <= '0;
        endcase
      end
    end
  end

  sel_fetch_a: assert property ((mode_reg == MODE_HALT) && !do_load
                                |=> SEQ_INSTR == INSTR_FETCH)
    else $error("Halted sequencer was not given the fetch instruction.");
  lamp_test_a: assert property ((in_s2.bus_view_select == VIEW_LAMP)
                                |=> BUS_LEDS == 8'hFF)
    else $error("Lamp test did not light every bus LED.");
  reset_clear_a: assert property (press[BTN_RESET]
                  |=> (addr_reg == 8'h00) && (fs_reg == 2'b00) && (mode_reg == MODE_HALT))
    else $error("Master reset left address, field or mode set.");
  halt_wait_a: assert property ((mode_reg == MODE_STOPPING) && !tick && !press[BTN_RESET]
                                |=> mode_reg == MODE_STOPPING)
    else $error("Machine stopped before the microcycle ended.");
  load_addr_a: assert property (do_load |=> addr_reg == $past(in_s2.input_switches))
    else $error("Load address did not copy the input switches.");
  deposit_keep_a: assert property (do_deposit |=> $stable(addr_reg) && $stable(fs_reg))
    else $error("Deposit moved the address or field select.");
  next_wrap_a: assert property (do_advance && (fs_reg == FIELD_LAST)
                                |=> (fs_reg == 2'b00) && (addr_reg == $past(addr_reg) + 8'h01))
    else $error("Field wrap did not advance the address.");
  step_once_a: assert property ((mode_reg == MODE_STEP) && tick && !press[BTN_RESET]
                                |=> mode_reg == MODE_HALT)
    else $error("Single step did not return to halt.");
  sync_pulse_a: assert property ((addr_reg == in_s2.input_switches) |=> ADDR_SYNC)
    else $error("Address sync missed a match.");
  seq_idle_a: assert property ((mode_reg == MODE_HALT) && !seq_pulse
                               |=> SEQUENCER_CLOCK)
    else $error("Sequencer clock left idle-high in halt.");
  host_gate_a: assert property (apb_access && PWRITE && (PADDR == OFF_HOST)
                  && (PWDATA[HOST_SEL_LSB +: 2] != HOST_SEL_CODE) && !press[BTN_DEP_NXT]
                  && !press[BTN_EXM_NXT] && !press[BTN_RESET] && !executing
                  |=> $stable(fs_reg))
    else $error("Host write outside the selected range advanced the field.");
  seq_pulse_a: assert property (seq_pulse && !executing |=> !SEQUENCER_CLOCK)
    else $error("Sequencer clock did not pulse for a halt-mode advance.");
  load_branch_a: assert property (do_load |=> (SEQ_INSTR == INSTR_PANEL_BRANCH)
                                  && (SEQ_BRANCH_ADDR == $past(in_s2.input_switches)))
    else $error("Load address did not present the panel branch.");

endmodule

//--- logic/panel_pkg.sv
/*
  Shared constants and types for the operator panel and control-word decode block:
  register offsets, field positions, sequencer codes, timing figures and carriers.
  Assumes a single 50 MHz system clock and an APB master with 32-bit data.
*/
package panel_pkg;

  // System clock and on-board oscillator rates, in hertz.
  localparam int CLK_HZ     = 50_000_000;
  localparam int OSC_HZ     = 2_000_000;
  localparam int OSC_DIV    = CLK_HZ / OSC_HZ;
  localparam int OSC_HIGH   = OSC_DIV / 2;
  localparam int OSC_CNT_W  = 5;

  // Contact bounce settling time, in milliseconds, and its cycle count.
  localparam int DEBOUNCE_MS     = 5;
  localparam int DEBOUNCE_CYCLES = (DEBOUNCE_MS * (CLK_HZ / 1000));
  localparam int DB_CNT_W        = 20;

  // APB register byte offsets.
  localparam logic [11:0] OFF_CTRL   = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_FIELD  = 12'h008;
  localparam logic [11:0] OFF_HOST   = 12'h00C;

  // Control register layout and reset value.
  localparam int          CTRL_HOST_EN_BIT = 0;
  localparam logic [31:0] CTRL_RESET       = 32'h0000_0001;

  // Status register layout.
  localparam int STAT_ADDR_LSB  = 0;
  localparam int STAT_FIELD_LSB = 8;
  localparam int STAT_MODE_LSB  = 12;

  // Host deposit word: data byte and host address high bits.
  localparam int          HOST_DATA_LSB = 0;
  localparam int          HOST_SEL_LSB  = 30;
  localparam logic [1:0]  HOST_SEL_CODE = 2'b11;

  // Sequencer instruction codes, bit order I3..I0.
  localparam logic [3:0] INSTR_PANEL_BRANCH = 4'h5;
  localparam logic [3:0] INSTR_FETCH        = 4'h2;

  // Control word field positions.
  localparam int CW_OE_LSB    = 0;
  localparam int CW_EX_LSB    = 2;
  localparam int CW_STK_LSB   = 4;
  localparam int CW_SHF_LSB   = 8;
  localparam int CW_ROTATE    = 14;
  localparam int CW_DEST_LSB  = 15;
  localparam int CW_SRC_LSB   = 18;
  localparam int CW_ALU_LSB   = 21;
  localparam int CW_BR_LSB    = 16;
  localparam int CW_SEQ_LSB   = 24;
  localparam int CW_MEMBUS    = 28;
  localparam int CW_CARRY     = 29;
  localparam int CW_SHIFT_CIN = 30;
  localparam int CW_MARKER    = 31;

  // Field select wrap point, bus view lamp test code and store depth.
  localparam logic [1:0] FIELD_LAST = 2'b11;
  localparam logic [1:0] VIEW_LAMP  = 2'b11;
  localparam int         STORE_WORDS = 256;

  // Momentary button indices.
  localparam int BTN_RESET   = 0;
  localparam int BTN_RUN     = 1;
  localparam int BTN_LOAD    = 2;
  localparam int BTN_DEPOSIT = 3;
  localparam int BTN_DEP_NXT = 4;
  localparam int BTN_EXM_NXT = 5;
  localparam int BTN_STEP    = 6;
  localparam int BTN_COUNT   = 7;

  // Machine modes, Gray coded along halt, run, stopping.
  typedef enum logic [1:0] {
    MODE_HALT     = 2'b00,
    MODE_RUN      = 2'b01,
    MODE_STOPPING = 2'b11,
    MODE_STEP     = 2'b10
  } mode_t;

  // Every asynchronous panel input, synchronised as one group.
  typedef struct packed {
    logic [7:0]           input_switches;
    logic [2:0]           multiway_switches;
    logic [1:0]           bus_view_select;
    logic                 clock_select;
    logic                 external_clock_input;
    logic [BTN_COUNT-1:0] buttons;
  } panel_in_t;

endpackage

//--- testbench/seq_model.sv
/*
  Behavioural sequencer facing the panel block: next address and inhibit.
  Assumes the block shows the current address on its address lamps.
*/
`timescale 1ns/100ps
module seq_model
  import panel_pkg::*;
(
  input  wire logic [7:0] addr,
  input  wire logic [3:0] instr,
  input  wire logic [7:0] branch_addr,
  output logic      [7:0] next_addr,
  output logic            inhibit
);
  // A fetch counts up; anything else branches, which is all this bench needs.
  assign next_addr = (instr === INSTR_FETCH) ? addr + 8'h01 : branch_addr;
  // Inhibit is low only in fetch cycles, so the arithmetic slice runs then.
  assign inhibit   = (instr !== INSTR_FETCH);
endmodule

//--- testbench/tb_top.sv
/*
  Self-checking bench for the panel control block: panel presses, APB, decode.
  Assumes the sequencer model beside it and a debounce limit of 4 cycles.
*/
`timescale 1ns/100ps
`define CMP(n, e, s) begin comparisons++; if ((e) !== (s)) begin miscompares++; $display("[ERR] %s exp %h seen %h", n, e, s); end end
module tb_top;
  import panel_pkg::*;
  typedef struct {int id; logic [31:0] e;} note_t;
  logic CLK_SYS = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, CLOCK_SELECT = 0;
  logic EXTERNAL_CLOCK_INPUT = 0, SHIFT_LEFT_OUT_N = 0, SHIFT_RIGHT_OUT_N = 1, er;
  logic [11:0] PADDR = 0;
  logic [31:0] PWDATA = 0, rd, r;
  logic [7:0]  INPUT_SWITCHES = 0, SHIFTER_IN_BUS = 0, DATA_OUT_BUS = 0, MEMORY_BUS = 0, a, c;
  logic [7:0]  b [4];
  logic [6:0]  PANEL_BUTTONS = 0;
  logic [2:0]  MULTIWAY_SWITCHES = 0;
  logic [1:0]  BUS_VIEW_SELECT = 0;
  wire logic [31:0] PRDATA;
  wire logic PREADY, PSLVERR, SYSTEM_CLOCK, SEQUENCER_CLOCK, SHIFT_LSB_IN_N, SHIFT_MSB_IN_N;
  wire logic ALU_EXECUTE_N, MEM_BUS_ENABLE, SLICE_CARRY_IN, SPARE_MARKER_BIT, ADDR_SYNC, RUN_LED;
  wire logic SEQUENCER_INHIBIT;
  wire logic [7:0] SEQ_NEXT_ADDR, SEQ_BRANCH_ADDR, BUS_LEDS, ADDRESS_LEDS, DATA_LEDS;
  wire logic [3:0] SEQ_INSTR, OUTPUT_ENABLE_N, STACK_INSTR;
  wire logic [2:0] SEQ_MULTIWAY, EXECUTE_ENABLE_N, ALU_DEST, ALU_SRC, ALU_INSTR;
  wire logic [5:0] SHIFTER_INSTR;
  wire logic [1:0] FIELD_LEDS;
  note_t q [$];
  int miscompares = 0, comparisons = 0;
  event res_ev;
  string nm [26] = '{"addr", "field", "data", "sync", "bus", "oe_n", "ex_n", "stack", "marker",
                     "membus", "carry", "instr", "seqclk", "run", "prdata", "pslverr",
                     "shf_instr", "alu_dest", "alu_src", "alu_instr", "lsb_in_n", "msb_in_n",
                     "alu_ex_n", "multiway", "branch", "sysclk"};

  // The debounce limit is cut short so that a press costs a few dozen cycles.
  panel_control #(.DEBOUNCE_LIMIT(4)) panel_control_inst (.CLK_SYS, .RST_N, .PSEL, .PENABLE,
    .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .INPUT_SWITCHES, .MULTIWAY_SWITCHES,
    .BUS_VIEW_SELECT, .CLOCK_SELECT, .EXTERNAL_CLOCK_INPUT, .PANEL_BUTTONS, .SEQ_NEXT_ADDR,
    .SEQUENCER_INHIBIT, .SHIFT_LEFT_OUT_N, .SHIFT_RIGHT_OUT_N, .SHIFTER_IN_BUS, .DATA_OUT_BUS,
    .MEMORY_BUS, .SYSTEM_CLOCK, .SEQUENCER_CLOCK, .SEQ_INSTR, .SEQ_BRANCH_ADDR, .SEQ_MULTIWAY,
    .OUTPUT_ENABLE_N, .EXECUTE_ENABLE_N, .STACK_INSTR, .SHIFTER_INSTR, .SHIFT_LSB_IN_N,
    .SHIFT_MSB_IN_N, .ALU_DEST, .ALU_SRC, .ALU_INSTR, .ALU_EXECUTE_N, .MEM_BUS_ENABLE,
    .SLICE_CARRY_IN, .SPARE_MARKER_BIT, .ADDR_SYNC, .BUS_LEDS, .ADDRESS_LEDS, .DATA_LEDS,
    .FIELD_LEDS, .RUN_LED);
  seq_model seq_model_inst (.addr(ADDRESS_LEDS), .instr(SEQ_INSTR), .branch_addr(SEQ_BRANCH_ADDR),
    .next_addr(SEQ_NEXT_ADDR), .inhibit(SEQUENCER_INHIBIT));

  // Clock at 50 MHz.
  always #10 CLK_SYS = ~CLK_SYS;

  // Picks the output that a note refers to.
  function automatic logic [31:0] obs(input int id);
    case (id)
      0: return ADDRESS_LEDS;   1: return FIELD_LEDS;       2: return DATA_LEDS;
      3: return ADDR_SYNC;      4: return BUS_LEDS;         5: return OUTPUT_ENABLE_N;
      6: return EXECUTE_ENABLE_N; 7: return STACK_INSTR;    8: return SPARE_MARKER_BIT;
      9: return MEM_BUS_ENABLE; 10: return SLICE_CARRY_IN;  11: return SEQ_INSTR;
      12: return SEQUENCER_CLOCK; 13: return RUN_LED;       14: return rd;
      15: return er;            16: return SHIFTER_INSTR;   17: return ALU_DEST;
      18: return ALU_SRC;       19: return ALU_INSTR;       20: return SHIFT_LSB_IN_N;
      21: return SHIFT_MSB_IN_N; 22: return ALU_EXECUTE_N;  23: return SEQ_MULTIWAY;
      24: return SEQ_BRANCH_ADDR; 25: return SYSTEM_CLOCK;
      default: return '0;
    endcase
  endfunction

  // Notes an expected result and tells the watcher that it is due.
  task automatic expect_(input int id, input logic [31:0] e);
    q.push_back('{id, e});
    ->res_ev;
  endtask

  // The watcher drains every note due so far, oldest first.
  initial forever begin
    @(res_ev);
    while (q.size() > 0) begin
      `CMP(nm[q[0].id], q[0].e, obs(q[0].id))
      void'(q.pop_front());
    end
  end

  task automatic settle(input int n);
    repeat (n) @(posedge CLK_SYS);
    #1;
  endtask

  // One APB transfer; the request stands until PREADY is sampled high.
  // A slave that never answers is caught by the watchdog, not by a local limit.
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge CLK_SYS);
    PSEL <= 1'b1; PENABLE <= 1'b0; PWRITE <= w; PADDR <= ad; PWDATA <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    do begin @(posedge CLK_SYS); end while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0; PENABLE <= 1'b0;
  endtask

  // A press is held and released longer than the debounce span.
  task automatic press(input int i, input logic [7:0] sw);
    @(posedge CLK_SYS);
    INPUT_SWITCHES <= sw; PANEL_BUTTONS[i] <= 1'b1;
    repeat (12) @(posedge CLK_SYS);
    PANEL_BUTTONS[i] <= 1'b0;
    settle(12);
  endtask

  task automatic report_and_stop;
    if (miscompares == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog well past the few hundred cycles the sequence needs.
  initial begin #400000; miscompares++; report_and_stop; end

  // Main sequence.
  initial begin
    void'($urandom(39));
    a = 8'($urandom); r = $urandom; c = 8'($urandom);
    b[0] = {r[3:1], 1'b1, 4'h4};
    b[1] = r[15:8]; b[2] = r[23:16]; b[3] = r[31:24];
    repeat (3) @(posedge CLK_SYS);
    RST_N <= 1'b1; MULTIWAY_SWITCHES <= c[2:0];
    settle(4);
    apb(0, OFF_CTRL, 0); expect_(14, CTRL_RESET);
    apb(0, 12'h010, 0); expect_(14, 0); expect_(15, 1);
    press(BTN_LOAD, a); expect_(0, a); expect_(3, 1);
    expect_(11, INSTR_FETCH); expect_(12, 1);
    press(BTN_DEPOSIT, b[0]); expect_(2, b[0]); expect_(0, a); expect_(1, 0);
    expect_(3, b[0] == a); expect_(8, b[0][7]); expect_(10, b[0][5]);
    expect_(9, b[0][4]);
    for (int i = 1; i < 4; i++) begin
      press(BTN_DEP_NXT, b[i]); expect_(1, i); expect_(2, b[i]);
    end
    expect_(5, 4'(~(4'b0001 << b[3][1:0])));
    expect_(6, 3'(b[3][3:2] == 2'b00 ? 3'b111 : ~(3'b001 << (b[3][3:2] - 2'd1))));
    expect_(7, b[3][7:4]);
    expect_(16, b[2][5:0]);
    expect_(17, {b[1][1:0], b[2][7]}); expect_(18, b[1][4:2]); expect_(19, b[1][7:5]);
    expect_(20, !b[2][6] && b[0][6]); expect_(21, b[2][6] || b[0][6]);
    expect_(22, 0);
    expect_(23, c[2:0]);
    expect_(24, b[1]);
    apb(0, OFF_STATUS, 0); expect_(14, {22'h0, 2'b11, a});
    apb(0, OFF_FIELD, 0); expect_(14, b[3]);
    press(BTN_DEP_NXT, c); expect_(0, 8'(a + 8'h01)); expect_(1, 0); expect_(2, c);
    apb(1, OFF_HOST, {2'b11, 22'h0, c ^ 8'h5A}); settle(4);
    expect_(1, 1); expect_(2, c ^ 8'h5A);
    apb(1, OFF_CTRL, 0); apb(1, OFF_HOST, {2'b11, 22'h0, c}); settle(4); expect_(1, 1);
    apb(1, OFF_CTRL, 1);
    apb(1, OFF_HOST, {2'b01, 22'h0, c}); settle(4); expect_(1, 1);
    press(BTN_RESET, c); expect_(0, 0); expect_(1, 0); expect_(13, 0);
    press(BTN_LOAD, a);
    press(BTN_EXM_NXT, a); expect_(1, 1); expect_(2, b[1]); expect_(0, a);
    press(BTN_STEP, a); settle(40); expect_(0, 8'(a + 8'h01)); expect_(13, 0);
    press(BTN_RUN, a); expect_(13, 1);
    press(BTN_RUN, a); settle(40); expect_(13, 0);
    for (int v = 0; v < 4; v++) begin
      @(posedge CLK_SYS);
      BUS_VIEW_SELECT <= 2'(v); SHIFTER_IN_BUS <= 8'($urandom); DATA_OUT_BUS <= 8'($urandom);
      MEMORY_BUS <= 8'($urandom); CLOCK_SELECT <= 1'b1; EXTERNAL_CLOCK_INPUT <= v[0];
      settle(6);
      expect_(4, v == 0 ? SHIFTER_IN_BUS : v == 1 ? DATA_OUT_BUS : v == 2 ? MEMORY_BUS : 8'hFF);
      expect_(25, v[0]);
    end
    settle(2);
    report_and_stop;
  end
endmodule
